// file: rtl/tcc16_edge.sv
/*
  Synchroniser, level filter and edge detector for one timer input pin.
  Assumes the pin is asynchronous to clk and holds each level for
  at least two clock periods.
*/
`timescale 1ns/10ps
module tcc16_edge (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic ce,
	input  wire logic pinIn,
	output logic      rise,
	output logic      fall
);
	import tcc16_pkg::*;

	logic                          meta;
	logic [EDGE_STABLE_CYCLES-1:0] hist;
	logic                          level;
	logic [EDGE_STABLE_CYCLES-1:0] next_hist;
	logic                          next_level;
	logic                          allHigh;
	logic                          allLow;

	always_comb begin
		next_hist = {hist[EDGE_STABLE_CYCLES-2:0], meta};
		allHigh = &hist;
		allLow = ~|hist;
		next_level = allHigh ? 1'h1 : (allLow ? 1'h0 : level);
		rise = allHigh & ~level;
		fall = allLow & level;
	end

	// The first stage feeds only the history shift register.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta <= 1'h0;
			hist <= '0;
			level <= 1'h0;
		end else if (ce) begin
			meta <= pinIn;
			hist <= next_hist;
			level <= next_level;
		end
	end
endmodule // tcc16_edge

// file: rtl/tcc16_pkg.sv
/*
  Constants and types shared by the 16-bit capture/compare timer.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package tcc16_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;

	localparam logic [7:0] OFS_COUNTER = 8'h00;
	localparam logic [7:0] OFS_CC_A    = 8'h04;
	localparam logic [7:0] OFS_CC_B    = 8'h08;
	localparam logic [7:0] OFS_MODE    = 8'h0C;
	localparam logic [7:0] OFS_CCCTL   = 8'h10;
	localparam logic [7:0] OFS_PRESC   = 8'h14;
	localparam logic [7:0] OFS_OUTCTL  = 8'h18;

	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] RST_CC    = 16'h0000;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [7:0]  RST_CTRL  = 8'h00;

	localparam logic [7:0] MODE_WMASK   = 8'h0F;
	localparam logic [7:0] CCCTL_WMASK  = 8'h07;
	localparam logic [7:0] PRESC_WMASK  = 8'hF3;
	localparam logic [7:0] OUTCTL_WMASK = 8'h07;

	localparam int MODE_OVF_BIT   = 0;
	localparam int MODE_RUN_LSB   = 2;
	localparam int CC_A_MODE_BIT  = 0;
	localparam int CC_A_TRIG_BIT  = 1;
	localparam int CC_B_MODE_BIT  = 2;
	localparam int PRE_CLK_LSB    = 0;
	localparam int PRE_EDGE_A_LSB = 4;
	localparam int PRE_EDGE_B_LSB = 6;
	localparam int OUT_EN_BIT     = 0;
	localparam int OUT_PPG_BIT    = 1;
	localparam int OUT_OSM_BIT    = 2;
	localparam int OUT_OST_BIT    = 3;

	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	localparam logic [1:0] CLK_DIV1  = 2'h0;
	localparam logic [1:0] CLK_DIV4  = 2'h1;
	localparam logic [1:0] CLK_DIV16 = 2'h2;
	localparam logic [1:0] CLK_EVENT = 2'h3;
	localparam logic [3:0] DIV4_LAST  = 4'h3;
	localparam logic [3:0] DIV16_LAST = 4'hF;

	localparam int EDGE_STABLE_CYCLES = 2;

	typedef enum logic [1:0] {
		TCC16_STOP,
		TCC16_FREE,
		TCC16_CLR_EDGE,
		TCC16_CLR_MATCH
	} tcc16_run_t;
endpackage

// file: rtl/tcc16_prescale.sv
/*
  Count clock generator: a one-cycle tick at a divided rate or on
  a qualified external edge.
  Assumes hold is raised while the counter must not advance.
*/
`timescale 1ns/10ps
module tcc16_prescale (
	input  wire logic       clk,
	input  wire logic       rstN,
	input  wire logic       ce,
	input  wire logic       hold,
	input  wire logic [1:0] sel,
	input  wire logic       eventEdge,
	output logic            tick
);
	import tcc16_pkg::*;

	logic [3:0] div;
	logic [3:0] next_div;
	logic       raw;

	always_comb begin
		next_div = div + 4'h1;
		unique case (sel)
			CLK_DIV1:  raw = 1'h1;
			CLK_DIV4:  raw = (div[1:0] == DIV4_LAST[1:0]);
			CLK_DIV16: raw = (div == DIV16_LAST);
			CLK_EVENT: raw = eventEdge;
		endcase
		// A held tick is dropped, not deferred, so counts can be lost.
		tick = raw & ~hold;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			div <= 4'h0;
		end else if (ce) begin
			div <= next_div;
		end
	end
endmodule // tcc16_prescale

// file: rtl/tcc16_top.sv
/*
  16-bit capture/compare timer with a classic Wishbone register slave.
  Assumes synchronous inputs apart from the two edge pins, which are
  synchronised here, and software that honours the setting limits.
*/
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/10ps
module tcc16_top (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire logic                         ce,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [tcc16_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [tcc16_pkg::DAT_W-1:0]  wb_dat_i,
	output logic      [tcc16_pkg::DAT_W-1:0]  wb_dat_o,
	output logic                              wb_ack_o,
	input  wire logic                         edgeInputA,
	input  wire logic                         edgeInputB,
	output logic                              timerOut,
	output logic                              matchIrqA,
	output logic                              matchIrqB
);
	import tcc16_pkg::*;

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) r[7:0] = d[7:0];
		if (s[1]) r[15:8] = d[15:8];
		return r;
	endfunction

	function automatic logic [7:0] merge8(input logic [7:0] old,
			input logic [31:0] d, input logic [3:0] s, input logic [7:0] m);
		return s[0] ? ((old & ~m) | (d[7:0] & m)) : old;
	endfunction

	function automatic logic validEdge(input logic [1:0] code,
			input logic r, input logic f);
		logic v;
		v = 1'h0;
		if (code == EDGE_FALL) v = f;
		if (code == EDGE_RISE) v = r;
		if (code == EDGE_BOTH) v = r | f;
		return v;
	endfunction

	logic [1:0]  rstPipe;
	logic        rstN;

	logic        ack;
	logic [31:0] rdata;
	logic        next_ack;
	logic [31:0] next_rdata;

	logic [15:0] upCounter;
	logic [15:0] ccA, ccB;
	logic [7:0]  timerMode;
	logic [7:0]  ccCtrl;
	logic [7:0]  presc;
	logic [7:0]  outCtl;
	logic        wrapped;
	logic        capPendA, capPendB;
	logic        armed, outLevel;
	logic        irqA, irqB;
	logic [15:0] next_upCounter;
	logic [15:0] next_ccA, next_ccB;
	logic [7:0]  next_timerMode;
	logic [7:0]  next_ccCtrl;
	logic [7:0]  next_presc;
	logic [7:0]  next_outCtl;
	logic        next_wrapped;
	logic        next_capPendA, next_capPendB;
	logic        next_armed, next_outLevel;
	logic        next_irqA, next_irqB;

	logic        req, newReq, wrStb, rdStb, cntRead;
	tcc16_run_t  runMode;
	logic        running;
	logic        aRise, aFall, bRise, bFall;
	logic        edgeA, edgeB, oppA;
	logic        capA, capB, tick;
	logic        hitA, hitB, cmpA, cmpB;
	logic        ostTrig, ovfEvent, clrNow;

	// Reset enters asynchronously, leaves through two stages on release.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe <= 2'h0;
		end else begin
			rstPipe <= {rstPipe[0], 1'h1};
		end
	end
	assign rstN = rstPipe[1];

	tcc16_edge u_edgeA (
		.clk   (clk),
		.rstN  (rstN),
		.ce    (ce),
		.pinIn (edgeInputA),
		.rise  (aRise),
		.fall  (aFall)
	);

	tcc16_edge u_edgeB (
		.clk   (clk),
		.rstN  (rstN),
		.ce    (ce),
		.pinIn (edgeInputB),
		.rise  (bRise),
		.fall  (bFall)
	);

	tcc16_prescale u_presc (
		.clk       (clk),
		.rstN      (rstN),
		.ce        (ce),
		.hold      (cntRead | ~running),
		.sel       (presc[PRE_CLK_LSB +: 2]),
		.eventEdge (edgeA),
		.tick      (tick)
	);

	always_comb begin
		req = wb_cyc_i & wb_stb_i;
		newReq = req & ~ack;
		wrStb = newReq & wb_we_i;
		rdStb = newReq & ~wb_we_i;
		// The whole counter read cycle stalls the count clock.
		cntRead = req & ~wb_we_i & (wb_adr_i == OFS_COUNTER);
		runMode = tcc16_run_t'(timerMode[MODE_RUN_LSB +: 2]);
		running = (runMode != TCC16_STOP);
		edgeA = validEdge(presc[PRE_EDGE_A_LSB +: 2], aRise, aFall);
		edgeB = validEdge(presc[PRE_EDGE_B_LSB +: 2], bRise, bFall);
		oppA = 1'h0;
		if (presc[PRE_EDGE_A_LSB +: 2] == EDGE_RISE) oppA = aFall;
		if (presc[PRE_EDGE_A_LSB +: 2] == EDGE_FALL) oppA = aRise;
		// Captures come from pin edges only, never from bus reads.
		capA = running & ccCtrl[CC_A_MODE_BIT]
			& (ccCtrl[CC_A_TRIG_BIT] ? oppA : edgeB);
		capB = running & ccCtrl[CC_B_MODE_BIT] & edgeA;
		// Zero matches only after a wrap, so a fresh start stays quiet.
		hitA = (upCounter == ccA) & ((upCounter != RST_COUNT) | wrapped);
		hitB = (upCounter == ccB) & ((upCounter != RST_COUNT) | wrapped);
		cmpA = running & tick & ~ccCtrl[CC_A_MODE_BIT] & hitA;
		cmpB = running & tick & ~ccCtrl[CC_B_MODE_BIT] & hitB;
		ostTrig = wrStb & (wb_adr_i == OFS_OUTCTL) & wb_sel_i[0]
			& wb_dat_i[OUT_OST_BIT] & outCtl[OUT_OSM_BIT];
		clrNow = ostTrig | ((runMode == TCC16_CLR_EDGE) & edgeA);
		ovfEvent = running & tick & ~clrNow & (upCounter == CNT_MAX)
			& ~((runMode == TCC16_CLR_MATCH) & (upCounter == ccA));
	end

	// Bus group: one wait state, ack for a single cycle.
	always_comb begin
		next_ack = newReq;
		next_rdata = rdata;
		if (rdStb) begin
			unique case (wb_adr_i)
				OFS_COUNTER: next_rdata = {16'h0000, upCounter};
				OFS_CC_A:    next_rdata = {16'h0000, ccA};
				OFS_CC_B:    next_rdata = {16'h0000, ccB};
				OFS_MODE:    next_rdata = {24'h000000, timerMode};
				OFS_CCCTL:   next_rdata = {24'h000000, ccCtrl};
				OFS_PRESC:   next_rdata = {24'h000000, presc};
				OFS_OUTCTL:  next_rdata = {24'h000000, outCtl};
				default:     next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ack <= 1'h0;
			rdata <= 32'h00000000;
		end else if (ce) begin
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end
	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;

	// Timer group.
	always_comb begin
		next_ccCtrl = ccCtrl;
		next_presc = presc;
		next_outCtl = outCtl;
		next_timerMode = timerMode;
		next_ccA = ccA;
		next_ccB = ccB;
		if (wrStb) begin
			unique case (wb_adr_i)
				OFS_CC_A:   next_ccA = merge16(ccA, wb_dat_i, wb_sel_i);
				OFS_CC_B:   next_ccB = merge16(ccB, wb_dat_i, wb_sel_i);
				OFS_MODE:   next_timerMode = merge8(timerMode, wb_dat_i,
					wb_sel_i, MODE_WMASK);
				OFS_CCCTL:  next_ccCtrl = merge8(ccCtrl, wb_dat_i,
					wb_sel_i, CCCTL_WMASK);
				OFS_PRESC:  next_presc = merge8(presc, wb_dat_i,
					wb_sel_i, PRESC_WMASK);
				OFS_OUTCTL: next_outCtl = merge8(outCtl, wb_dat_i,
					wb_sel_i, OUTCTL_WMASK);
				default:    next_ccA = ccA;
			endcase
		end
		// Overflow set beats a software clear in the same cycle.
		if (ovfEvent) next_timerMode[MODE_OVF_BIT] = 1'h1;
		// A stop leaves both registers as they are; nothing is promised.
		if (capA) next_ccA = upCounter;
		if (capB) next_ccB = upCounter;

		next_wrapped = wrapped;
		next_upCounter = upCounter;
		if (!running) begin
			next_upCounter = RST_COUNT;
			next_wrapped = 1'h0;
		end else if (clrNow) begin
			next_upCounter = RST_COUNT;
			next_wrapped = 1'h0;
		end else if (tick) begin
			if ((runMode == TCC16_CLR_MATCH) && (upCounter == ccA)) begin
				next_upCounter = RST_COUNT;
			end else begin
				next_upCounter = upCounter + CNT_ONE;
			end
			if (ovfEvent) next_wrapped = 1'h1;
		end

		next_capPendA = capA | (capPendA & ~tick);
		next_capPendB = capB | (capPendB & ~tick);
		next_irqA = cmpA | (tick & capPendA);
		next_irqB = cmpB | (tick & capPendB);

		next_armed = armed;
		next_outLevel = outLevel;
		if (!outCtl[OUT_EN_BIT]) begin
			next_outLevel = 1'h0;
			next_armed = 1'h0;
		end else if (outCtl[OUT_OSM_BIT]) begin
			if (ostTrig) next_armed = 1'h1;
			if (armed & cmpB) next_outLevel = 1'h1;
			if (armed & cmpA) begin
				next_outLevel = 1'h0;
				next_armed = 1'h0;
			end
		end else if (outCtl[OUT_PPG_BIT]) begin
			if (cmpB) next_outLevel = 1'h0;
			if (cmpA) next_outLevel = 1'h1;
		end else if (cmpA | cmpB) begin
			next_outLevel = ~outLevel;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			upCounter <= RST_COUNT;
			ccA <= RST_CC;
			ccB <= RST_CC;
			timerMode <= RST_CTRL;
			ccCtrl <= RST_CTRL;
			presc <= RST_CTRL;
			outCtl <= RST_CTRL;
			wrapped <= 1'h0;
			capPendA <= 1'h0;
			capPendB <= 1'h0;
			armed <= 1'h0;
			outLevel <= 1'h0;
			irqA <= 1'h0;
			irqB <= 1'h0;
		end else if (ce) begin
			upCounter <= next_upCounter;
			ccA <= next_ccA;
			ccB <= next_ccB;
			timerMode <= next_timerMode;
			ccCtrl <= next_ccCtrl;
			presc <= next_presc;
			outCtl <= next_outCtl;
			wrapped <= next_wrapped;
			capPendA <= next_capPendA;
			capPendB <= next_capPendB;
			armed <= next_armed;
			outLevel <= next_outLevel;
			irqA <= next_irqA;
			irqB <= next_irqB;
		end
	end
	assign timerOut = outLevel;
	assign matchIrqA = irqA;
	assign matchIrqB = irqB;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	a_stop_clears: assert property (ce && !running
		|=> upCounter == 16'h0000)
		else $error("counter not cleared while stopped");
	a_count_step: assert property (ce && tick && runMode == TCC16_FREE
		&& !clrNow && !wrStb |=> upCounter == $past(upCounter) + 16'h0001)
		else $error("counter did not step on tick");
	a_read_stall: assert property (ce && cntRead && running
		&& !clrNow |=> upCounter == $past(upCounter))
		else $error("counter moved during read");
	a_reset_zero: assert property ($rose(rstN) |-> ccA == 16'h0000
		&& ccB == 16'h0000 && upCounter == 16'h0000)
		else $error("registers not zero after reset");
	a_match_irq: assert property (ce && cmpA |=> matchIrqA
		##1 (!matchIrqA || capPendA))
		else $error("match interrupt missing");
	a_zero_wrap: assert property (ce && tick && running && !clrNow
		&& runMode != TCC16_CLR_MATCH && !ccCtrl[CC_B_MODE_BIT]
		&& ccB == 16'h0000 && upCounter == 16'h0000 && wrapped
		|=> matchIrqB && upCounter == 16'h0001)
		else $error("zero compare after wrap missed");
	a_capture_b: assert property (ce && capB
		|=> ccB == $past(upCounter))
		else $error("register B capture wrong");
	a_cap_wins: assert property (ce && capA && wrStb
		&& wb_adr_i == OFS_CC_A |=> ccA == $past(upCounter))
		else $error("bus write beat capture");
	a_cmp_ignore: assert property (ce && !ccCtrl[CC_A_MODE_BIT]
		&& !(wrStb && wb_adr_i == OFS_CC_A) |=> $stable(ccA))
		else $error("compare register changed");
	a_cap_irq_defer: assert property (ce && capA && !tick
		&& !cmpA |=> !matchIrqA)
		else $error("capture interrupt not deferred");
	a_ack_pulse: assert property (ack |=> !ack)
		else $error("ack held longer than one cycle");

	c_match_a: cover property (cmpA ##1 matchIrqA);
	c_capture_b: cover property (capB ##[1:40] matchIrqB);
	c_overflow: cover property (ovfEvent);
	c_toggle: cover property ($changed(timerOut));
endmodule // tcc16_top

// file: testbench/tb_timer_capture_compare16.sv
/*
  Self-checking bench for the 16-bit capture/compare timer.
  Assumes the pin model in tcc16_pin_model and a one-cycle bus slave.
*/
`timescale 1ns/10ps
module tb_timer_capture_compare16;
	import tcc16_pkg::*;
	logic        clk = 1'b0;
	logic        rstB = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack, pinA, pinB, tOut, irqA, irqB;
	logic        outPrev = 1'b0;
	logic [1:0]  codes [3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
	int mismatches = 0, n_compared = 0, cycle = 0;
	int nA = 0, nB = 0, lastA = 0, perA = 0;
	int lastTog = 0, togInt = 0, lastRise = 0, perOut = 0, hiOut = 0;

	always #2 clk = ~clk;

	tcc16_top dut_u (
		.clk(clk), .rst_b(rstB), .ce(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.edgeInputA(pinA), .edgeInputB(pinB), .timerOut(tOut),
		.matchIrqA(irqA), .matchIrqB(irqB)
	);

	tcc16_pin_model pin_u (.clk(clk), .pinA(pinA), .pinB(pinB));

	always @(posedge clk) begin
		cycle <= cycle + 1;
		outPrev <= tOut;
		if (irqA === 1'b1) begin
			nA <= nA + 1;
			perA <= cycle - lastA;
			lastA <= cycle;
		end
		if (irqB === 1'b1)
			nB <= nB + 1;
		if (tOut !== outPrev) begin
			togInt <= cycle - lastTog;
			lastTog <= cycle;
			if (tOut === 1'b1) begin
				perOut <= cycle - lastRise;
				lastRise <= cycle;
			end else begin
				hiOut <= cycle - lastRise;
			end
		end
	end

	task automatic fail(input string msg);
		mismatches++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask

	task automatic chkEq(input logic [31:0] got, input logic [31:0] exp,
			input string msg);
		n_compared++;
		if (got !== exp)
			fail($sformatf("%s got %h want %h", msg, got, exp));
	endtask

	task automatic chkIn(input logic [31:0] got, input int lo, input int hi,
			input string msg);
		n_compared++;
		if ($isunknown(got) || got < lo || got > hi)
			fail($sformatf("%s got %0d want %0d..%0d", msg, got, lo, hi));
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wb(input logic [7:0] a, input bit w, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'h3;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 64);
		if (n >= 64)
			fail("bus timeout");
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(a, 1'b0, 32'h0, q);
	endtask

	task automatic setup(input logic [7:0] ctl, input logic [7:0] pre,
			input logic [7:0] outc, input logic [15:0] a,
			input logic [15:0] b, input tcc16_run_t run);
		wr(OFS_MODE, 32'h0);
		wr(OFS_CC_A, 32'(a));
		wr(OFS_CC_B, 32'(b));
		wr(OFS_CCCTL, 32'(ctl));
		wr(OFS_PRESC, 32'(pre));
		wr(OFS_OUTCTL, 32'(outc));
		wr(OFS_MODE, 32'(run) << MODE_RUN_LSB);
	endtask

	function automatic bit expCap(input int k, input logic [1:0] c,
			input bit rise);
		if (k == 1)
			return c != EDGE_BOTH && rise == (c == EDGE_FALL);
		return c == EDGE_BOTH || rise == (c == EDGE_RISE);
	endfunction

	// Kind 0 captures into register B, kinds 1 and 2 into register A.
	task automatic capStep(input int k, input logic [1:0] code, input bit lv);
		logic [31:0] pre, post, q;
		int base;
		rd((k == 0) ? OFS_CC_B : OFS_CC_A, pre);
		base = (k == 0) ? nB : nA;
		rd(OFS_COUNTER, q);
		pin_u.drive(k == 2, lv);
		repeat (8) @(posedge clk);
		rd((k == 0) ? OFS_CC_B : OFS_CC_A, post);
		if (expCap(k, code, lv)) begin
			chkIn(post, pre + 1, 16'hFFFF, "capture");
			chkEq(((k == 0) ? nB : nA) - base, 1, "capture irq");
		end else begin
			chkEq(post, pre, "no capture");
			chkEq(((k == 0) ? nB : nA) - base, 0, "no capture irq");
		end
	endtask

	initial begin
		logic [31:0] q, v0;
		int n, w, l, t0, bA, bB, m;
		void'($urandom(32'hD520));
		repeat (4) @(posedge clk);
		rstB <= 1'b1;
		repeat (3) @(posedge clk);
		rd(OFS_COUNTER, q);
		chkEq(q, 32'(RST_COUNT), "counter reset");
		rd(OFS_CC_A, q);
		chkEq(q, 32'(RST_CC), "cc A reset");
		rd(OFS_CC_B, q);
		chkEq(q, 32'(RST_CC), "cc B reset");
		rd(8'h1C, q);
		chkEq(q, 32'h0, "unmapped read");
		v0 = $urandom_range(1, 65535);
		wr(OFS_CC_B, v0 | 32'hFFFF_0000);
		rd(OFS_CC_B, q);
		chkEq(q, v0, "cc B read back");
		wr(OFS_COUNTER, 32'h1234);
		rd(OFS_COUNTER, q);
		chkEq(q, 32'h0, "counter read only");
		$display("test reset done");

		wr(OFS_MODE, 32'(TCC16_FREE) << MODE_RUN_LSB);
		repeat (50) @(posedge clk);
		rd(OFS_COUNTER, q);
		chkIn(q, 48, 56, "counter runs");
		v0 = q;
		rd(OFS_COUNTER, q);
		chkIn(q, v0 + 1, v0 + 6, "counter steps");
		v0 = q;
		ce <= 1'b0;
		repeat (10) @(posedge clk);
		ce <= 1'b1;
		rd(OFS_COUNTER, q);
		chkIn(q, v0 + 1, v0 + 6, "clock enable freeze");
		wr(OFS_MODE, 32'h0);
		rd(OFS_COUNTER, q);
		chkEq(q, 32'h0, "stop clears");
		repeat (20) @(posedge clk);
		rd(OFS_COUNTER, q);
		chkEq(q, 32'h0, "stays stopped");
		$display("test run done");

		n = $urandom_range(20, 83);
		w = $urandom_range(2, n - 1);
		for (int k = 1; k <= 3; k += 2) begin
			setup(8'h00, 8'h00, k[7:0], n[15:0], (k == 1) ? 16'h0 : w[15:0],
				TCC16_CLR_MATCH);
			repeat (4 * n + 20) @(posedge clk);
			chkEq(perA, n + 1, "match period");
			if (k == 1) begin
				chkEq(togInt, n + 1, "square half period");
			end else begin
				chkEq(perOut, n + 1, "pulse period");
				chkIn(hiOut, w, w + 1, "pulse width");
			end
		end
		$display("test compare done");

		for (int k = 0; k < 3; k++) begin
			for (int c = 0; c < 3; c++) begin
				setup((k == 0) ? 8'h04 : ((k == 1) ? 8'h03 : 8'h01),
					(k == 2) ? {codes[c], 6'h0} : {2'h0, codes[c], 4'h0},
					8'h00, 16'h0, 16'h0, TCC16_FREE);
				capStep(k, codes[c], 1'b1);
				capStep(k, codes[c], 1'b0);
			end
		end
		$display("test capture done");

		m = $urandom_range(3, 9);
		setup(8'h00, 8'h13, 8'h00, 16'h0, 16'h0, TCC16_FREE);
		for (int i = 0; i < m; i++) begin
			pin_u.drive(1'b0, 1'b1);
			pin_u.drive(1'b0, 1'b0);
		end
		rd(OFS_COUNTER, q);
		chkEq(q, m, "event count");
		setup(8'h00, 8'h10, 8'h00, 16'h0, 16'h0, TCC16_CLR_EDGE);
		repeat (30) @(posedge clk);
		pin_u.drive(1'b0, 1'b1);
		rd(OFS_COUNTER, q);
		chkIn(q, 1, 8, "edge clear");
		pin_u.drive(1'b0, 1'b0);
		setup(8'h00, 8'h00, 8'h05, n[15:0], w[15:0], TCC16_FREE);
		wr(OFS_OUTCTL, 32'h0000_000D);
		rd(OFS_COUNTER, q);
		chkIn(q, 1, 8, "one-shot clear");
		repeat (n + 10) @(posedge clk);
		chkEq(hiOut, n - w, "one-shot width");
		$display("test clear modes done");

		l = $urandom_range(300, 800);
		setup(8'h00, 8'h00, 8'h00, l[15:0], 16'h0, TCC16_FREE);
		t0 = cycle;
		bA = nA;
		bB = nB;
		repeat (1000) @(posedge clk);
		chkEq(nA - bA, 1, "single match");
		chkEq(nB - bB, 0, "no zero match at start");
		wr(OFS_CC_A, 32'(l - 100));
		n = 0;
		while (nB == bB && n < 70000) begin
			@(posedge clk);
			n++;
		end
		chkIn(cycle - t0, 65525, 65545, "zero match after wrap");
		chkEq(nA - bA, 1, "no match before wrap");
		repeat (l) @(posedge clk);
		chkEq(nA - bA, 2, "match after wrap");
		wr(OFS_MODE, 32'h0);
		$display("test wrap done");
		conclude();
	end

	// The wrap test alone needs some 66000 cycles.
	initial begin
		repeat (90000) @(posedge clk);
		fail("watchdog expired");
		conclude();
	end
endmodule // tb_timer_capture_compare16

// file: testbench/tcc16_pin_model.sv
/*
  Model of the two external pulse sources on the timer's edge pins.
  Assumes the bench calls drive just after a rising clock edge.
*/
`timescale 1ns/10ps
module tcc16_pin_model #(
	parameter int HOLD = 6
) (
	input  wire logic clk,
	output logic      pinA,
	output logic      pinB
);
	initial begin
		pinA = 1'b0;
		pinB = 1'b0;
	end

	// Each level is held for several clocks, so that the input
	// filter sees it; pulses shorter than two clocks are lost.
	task automatic drive(input bit useB, input bit level);
		if (useB) begin
			pinB <= level;
		end else begin
			pinA <= level;
		end
		repeat (HOLD) @(posedge clk);
	endtask
endmodule // tcc16_pin_model
